/* rtl/ttd_defs.svh */
// transient threshold/debounce: register offsets, field positions, resets
// assumes inclusion by rtl/ttd_transient_detect.sv; rtl/ttd_pkg.sv does not include it
`ifndef TTD_DEFS_SVH
`define TTD_DEFS_SVH

// register offsets
`define TTD_CFG_ADDR        8'h1d
`define TTD_SRC_ADDR        8'h1e
`define TTD_THS_ADDR        8'h1f
`define TTD_CNT_ADDR        8'h20

// configuration register fields
`define TTD_CFG_BYPASS      0
`define TTD_CFG_XEN         1
`define TTD_CFG_ZEN         3
`define TTD_CFG_LATCH       4

// source register fields
`define TTD_SRC_XPOL        0
`define TTD_SRC_XEVT        1
`define TTD_SRC_ACTIVE      6

// threshold register fields
`define TTD_THS_MODE        7
`define TTD_THS_MSB         6

// reset values
`define TTD_CFG_RESET       8'h00
`define TTD_THS_RESET       8'h00
`define TTD_CNT_RESET       8'h00

// debounce step as log2 of multiples of 1.25 ms
`define TTD_FLOOR_NORMAL    4'h4
`define TTD_FLOOR_LOWNOISE  4'h6
`define TTD_FLOOR_HIGH_RESOLUTION_MODE   4'h1
`define TTD_FLOOR_LOWPOWER  4'h7
`define TTD_PERIOD_12HZ5    4'h6
`define TTD_PERIOD_6HZ25    4'h7
`define TTD_PERIOD_1HZ56    4'h9
`define TTD_CNT_MAX         9'h0ff

`endif

/* rtl/ttd_pkg.sv */
// transient threshold/debounce: shared types
// assumes ttd_defs.svh holds all numeric constants
package ttd_pkg;

   // active oversampling mode
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_LOW_NOISE_LOW_POWER,
      MODE_HIGH_RESOLUTION,
      MODE_LOW_POWER
   } ttd_mode_type;

   // output sample rate code: 0 = 800 Hz ... 7 = 1.56 Hz, halving per step except 4 to 5 and 6 to 7, which quarter
   typedef logic [2:0] ttd_rate_type;

   // one sample, three signed axes at 0.063 g per lsb over +/-8 g
   typedef struct packed {
      logic signed [7:0] zAxis;
      logic signed [7:0] yAxis;
      logic signed [7:0] xAxis;
   } ttd_sample_type;

   // register access request from the serial port logic
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } ttd_reg_req_type;

   // whole state of the detector
   typedef struct packed {
      logic [7:0] cfg_r;
      logic [7:0] ths_r;
      logic [7:0] cnt_r;
      logic [7:0] src_r;
      logic [7:0] debounce_r;
      logic [7:0] rdData_r;
   } ttd_state_type;

endpackage : ttd_pkg

/* rtl/ttd_transient_detect.sv */
// transient threshold and debounce stage with its four registers
// assumes samples and register requests arrive on ref_clk, one-cycle strobes
//
// Overview of operation
// - mode bit clear: counter steps up on qualifying samples, down otherwise.
// - mode bit set: counter steps up on qualifying samples, clears otherwise.
// - seven-bit threshold in low bits, always applied on the +/-8 g scale.
// - event declared once counter reaches programmed count of exceeding steps.
// - eight-bit read/write count register, resets to zero.
// - counter advances once per debounce time step.
// - step equals sample period, capped at a per-mode floor.
// - exceeding enabled axis raises its flag, polarity and the interrupt.
// - bypass bit feeds unfiltered data to the comparison.
// - with latching, flags freeze once active; source read clears all.
// - each axis assessed only when its enable is set; enables reset off.
`timescale 1ns/1ps
`include "ttd_defs.svh"

module ttd_transient_detect (
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   input  wire ttd_pkg::ttd_reg_req_type regReq,
   output logic [7:0]                    regRdData,
   input  wire logic                     sampleValid,
   input  wire ttd_pkg::ttd_sample_type  filteredSample,
   input  wire ttd_pkg::ttd_sample_type  rawSample,
   input  wire ttd_pkg::ttd_rate_type    outputSampleRate,
   input  wire ttd_pkg::ttd_mode_type    oversampleMode,
   output logic                          transientIrq,
   output logic [7:0]                    debounceLevel
);
   import ttd_pkg::*;

   ttd_state_type  state_r;
   ttd_state_type  state_nxt;
   ttd_sample_type useSample;
   logic [2:0]     axisOver;
   logic [2:0]     axisNeg;
   logic           qualify;
   logic [3:0]     periodExp;
   logic [3:0]     floorExp;
   logic [3:0]     stepShift;
   logic [8:0]     stepInc;
   logic [8:0]     upSum;
   logic [7:0]     upCount;
   logic [7:0]     downCount;
   logic           fire;
   logic           readSrc;

   // ------------------------------------------------------------------
   // threshold comparison
   // ------------------------------------------------------------------
   // data path choice
   assign useSample = state_r.cfg_r[`TTD_CFG_BYPASS] ? rawSample
                                                     : filteredSample;

   // magnitude is unsigned 8 bits so -128 compares as 128, no overflow
   always_comb
   begin
      logic signed [7:0] axisVal;
      logic [7:0]        axisMag;
      axisVal  = 8'sh00;
      axisMag  = 8'h00;
      axisOver = 3'h0;
      axisNeg  = 3'h0;
      for (int i = 0; i < 3; i++)
      begin
         axisVal = useSample[i*8 +: 8];
         axisMag = axisVal[7] ? 8'(-axisVal) : 8'(axisVal);
         axisNeg[i]  = axisVal[7];
         axisOver[i] = state_r.cfg_r[`TTD_CFG_XEN + i]
                       && (axisMag >
                           {1'b0, state_r.ths_r[`TTD_THS_MSB:0]});
      end
   end

   assign qualify = |axisOver;

   // ------------------------------------------------------------------
   // debounce step length
   // ------------------------------------------------------------------
   // every sample period and floor is 1.25 ms times a power of two, so a
   // step shorter than the sample period becomes a wider increment
   always_comb
   begin
      unique case (outputSampleRate)
         3'h5:    periodExp = `TTD_PERIOD_12HZ5;
         3'h6:    periodExp = `TTD_PERIOD_6HZ25;
         3'h7:    periodExp = `TTD_PERIOD_1HZ56;
         default: periodExp = {1'b0, outputSampleRate};
      endcase
      unique case (oversampleMode)
         MODE_NORMAL:              floorExp = `TTD_FLOOR_NORMAL;
         MODE_LOW_NOISE_LOW_POWER: floorExp = `TTD_FLOOR_LOWNOISE;
         MODE_HIGH_RESOLUTION:     floorExp = `TTD_FLOOR_HIGH_RESOLUTION_MODE;
         MODE_LOW_POWER:           floorExp = `TTD_FLOOR_LOWPOWER;
      endcase
      stepShift = (periodExp > floorExp) ? 4'(periodExp - floorExp)
                                         : 4'h0;
   end

   assign stepInc   = 9'h001 << stepShift;
   assign upSum     = {1'b0, state_r.debounce_r} + stepInc;
   assign upCount   = (upSum > `TTD_CNT_MAX) ? 8'hff : upSum[7:0];
   assign downCount = ({1'b0, state_r.debounce_r} > stepInc)
                      ? 8'(state_r.debounce_r - stepInc[7:0]) : 8'h00;
   assign fire      = sampleValid && qualify
                      && (upCount >= state_r.cnt_r);
   assign readSrc   = regReq.rdEn && (regReq.addr == `TTD_SRC_ADDR);

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;

      if (regReq.wrEn)
      begin
         unique case (regReq.addr)
            `TTD_CFG_ADDR: state_nxt.cfg_r = regReq.wrData;
            `TTD_THS_ADDR: state_nxt.ths_r = regReq.wrData;
            `TTD_CNT_ADDR: state_nxt.cnt_r = regReq.wrData;
            default:       state_nxt.cfg_r = state_r.cfg_r;
         endcase
      end

      if (regReq.rdEn)
      begin
         unique case (regReq.addr)
            `TTD_CFG_ADDR: state_nxt.rdData_r = state_r.cfg_r;
            `TTD_SRC_ADDR: state_nxt.rdData_r = state_r.src_r;
            `TTD_THS_ADDR: state_nxt.rdData_r = state_r.ths_r;
            `TTD_CNT_ADDR: state_nxt.rdData_r = state_r.cnt_r;
            default:       state_nxt.rdData_r = 8'h00;
         endcase
      end

      // reading the source clears it; a same-cycle event below still wins
      if (readSrc)
         state_nxt.src_r = 8'h00;

      if (sampleValid)
      begin
         if (qualify)
            state_nxt.debounce_r = upCount;
         else if (state_r.ths_r[`TTD_THS_MODE])
            state_nxt.debounce_r = 8'h00;
         else
            state_nxt.debounce_r = downCount;

         if (state_r.cfg_r[`TTD_CFG_LATCH]
             && state_r.src_r[`TTD_SRC_ACTIVE] && !readSrc)
            state_nxt.src_r = state_r.src_r;
         else if (fire)
         begin
            state_nxt.src_r = 8'h00;
            state_nxt.src_r[`TTD_SRC_ACTIVE] = 1'b1;
            for (int i = 0; i < 3; i++)
            begin
               state_nxt.src_r[`TTD_SRC_XEVT + 2*i] = axisOver[i];
               state_nxt.src_r[`TTD_SRC_XPOL + 2*i] = axisOver[i]
                                                      && axisNeg[i];
            end
         end
         else if (!state_r.cfg_r[`TTD_CFG_LATCH])
            state_nxt.src_r = 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r.cfg_r      <= `TTD_CFG_RESET;
         state_r.ths_r      <= `TTD_THS_RESET;
         state_r.cnt_r      <= `TTD_CNT_RESET;
         state_r.src_r      <= 8'h00;
         state_r.debounce_r <= 8'h00;
         state_r.rdData_r   <= 8'h00;
      end
      else
         state_r <= state_nxt;
   end

   assign regRdData     = state_r.rdData_r;
   assign transientIrq  = state_r.src_r[`TTD_SRC_ACTIVE];
   assign debounceLevel = state_r.debounce_r;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_count_up_sat: assert property (
      sampleValid && qualify |=> debounceLevel ==
         ((({1'b0, $past(debounceLevel)} + $past(stepInc)) > 9'h0ff)
          ? 8'hff : 8'($past(debounceLevel) + $past(stepInc[7:0]))))
      else $error("debounce counter did not step up or saturate");
   a_count_down: assert property (
      sampleValid && !qualify && !state_r.ths_r[`TTD_THS_MODE]
      && stepShift == 4'h0
      |=> debounceLevel == (($past(debounceLevel) == 8'h00)
                            ? 8'h00 : 8'($past(debounceLevel) - 8'h01)))
      else $error("debounce counter did not step down by one");
   a_count_clear: assert property (
      sampleValid && !qualify && state_r.ths_r[`TTD_THS_MODE]
      |=> debounceLevel == 8'h00)
      else $error("debounce counter not cleared in clear mode");
   a_zero_count_fires: assert property (
      sampleValid && qualify && state_r.cnt_r == 8'h00
      && !state_r.src_r[`TTD_SRC_ACTIVE] |=> transientIrq)
      else $error("zero count did not fire on first sample");
   a_no_early_event: assert property (
      sampleValid && !transientIrq && !readSrc
      && (!qualify || upCount < state_r.cnt_r) |=> !transientIrq)
      else $error("event declared before count reached");
   a_latch_freeze: assert property (
      state_r.cfg_r[`TTD_CFG_LATCH] && transientIrq && !readSrc
      |=> $stable(state_r.src_r))
      else $error("latched source bits changed");
   a_read_clears: assert property (
      readSrc && !sampleValid ##1 !sampleValid && !readSrc
      |-> state_r.src_r == 8'h00 && !transientIrq)
      else $error("source read did not clear flags");
   a_axis_disabled: assert property (
      sampleValid && state_r.cfg_r[`TTD_CFG_ZEN:`TTD_CFG_XEN] == 3'h0
      && !transientIrq |=> !transientIrq)
      else $error("event raised with all axes disabled");
   a_count_write: assert property (
      regReq.wrEn && regReq.addr == `TTD_CNT_ADDR
      |=> state_r.cnt_r == $past(regReq.wrData))
      else $error("count register write lost");
   a_step_floor: assert property (
      oversampleMode == MODE_NORMAL && outputSampleRate == 3'h7
      |-> stepInc == 9'h020)
      else $error("normal mode step at slowest rate wrong");

   c_event_fire:   cover property (sampleValid && fire);
   c_latched_hold: cover property (transientIrq
                                   && state_r.cfg_r[`TTD_CFG_LATCH]
                                   ##1 sampleValid && fire);
   c_clear_mode:   cover property (sampleValid && !qualify
                                   && state_r.ths_r[`TTD_THS_MODE]
                                   && state_r.debounce_r != 8'h00);
   c_read_clear:   cover property (readSrc && transientIrq);

endmodule : ttd_transient_detect

/* tb/ttd_host_model.sv */
// host side of the register port: one-cycle write and read strobes
// assumes callers run after reset release, on ref_clk
`timescale 1ns/1ps
module ttd_host_model
   import ttd_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic [7:0]          regRdData,
   output ttd_pkg::ttd_reg_req_type regReq
);
   initial regReq = '0;
   // idle address and data are inverted so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) regReq <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk) regReq <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   // a source read also clears the event, as the device expects
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk) regReq <= '{1'b0, 1'b1, a, 8'h5a};
      @(posedge ref_clk) regReq <= '{1'b0, 1'b0, ~a, 8'ha5};
      #1 d = regRdData;
   endtask : rd
endmodule : ttd_host_model

/* tb/tb.sv */
// bench for the transient threshold/debounce stage
// assumes the host model owns the register port; bench drives samples
`timescale 1ns/1ps
module tb;
   import ttd_pkg::*;
   logic            ref_clk = 1'b0;
   logic            reset = 1'b1;
   ttd_reg_req_type regReq;
   logic [7:0]      regRdData;
   logic            sampleValid = 1'b0;
   ttd_sample_type  filteredSample = '0;
   ttd_sample_type  rawSample = '0;
   ttd_rate_type    outputSampleRate = 3'h0;
   ttd_mode_type    oversampleMode = MODE_NORMAL;
   logic            transientIrq;
   logic [7:0]      debounceLevel;
   int              n_errors = 0;
   int              comparisons = 0;
   int              cycles = 0;
   // step size at the slowest rate, per mode; high-res saturates
   logic [7:0]      modeInc [4] = '{8'h20, 8'h08, 8'hff, 8'h04};

   ttd_host_model host (.ref_clk(ref_clk), .regRdData(regRdData),
                        .regReq(regReq));
   ttd_transient_detect dut (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .regReq          (regReq),
      .regRdData       (regRdData),
      .sampleValid     (sampleValid),
      .filteredSample  (filteredSample),
      .rawSample       (rawSample),
      .outputSampleRate(outputSampleRate),
      .oversampleMode  (oversampleMode),
      .transientIrq    (transientIrq),
      .debounceLevel   (debounceLevel)
   );

   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // a hang cannot outlast this many cycles
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdChk(input string nm, input logic [7:0] a,
                        input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(nm, exp, d);
   endtask : rdChk

   // one sample on the x axis; y and z stay quiet
   task automatic samp(input logic [7:0] fx, input logic [7:0] rx,
                       input logic [7:0] expLvl);
      @(posedge ref_clk)
      begin
         sampleValid <= 1'b1;
         filteredSample <= '{8'h00, 8'h00, fx};
         rawSample <= '{8'h00, 8'h00, rx};
      end
      @(posedge ref_clk) sampleValid <= 1'b0;
      #1 chk("debounceLevel", expLvl, debounceLevel);
   endtask : samp

   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      rdChk("cfg reset", 8'h1d, 8'h00);
      rdChk("ths reset", 8'h1f, 8'h00);
      rdChk("cnt reset", 8'h20, 8'h00);
      rdChk("unmapped", 8'h55, 8'h00);
      host.wr(8'h20, 8'ha7);
      rdChk("cnt rw", 8'h20, 8'ha7);
      $display("test registers done");

      host.wr(8'h20, 8'h02);
      host.wr(8'h1f, 8'h10);
      host.wr(8'h1d, 8'h02);
      samp(8'h20, 8'h00, 8'h01);
      chk("irq early", 8'h00, {7'h0, transientIrq});
      samp(8'he0, 8'h00, 8'h02);
      chk("irq fire", 8'h01, {7'h0, transientIrq});
      rdChk("source", 8'h1e, 8'h43);
      chk("irq clear", 8'h00, {7'h0, transientIrq});
      $display("test event done");

      host.wr(8'h20, 8'hff);
      samp(8'h10, 8'h00, 8'h01);
      samp(8'h11, 8'h00, 8'h02);
      samp(8'h00, 8'h7f, 8'h01);
      host.wr(8'h1d, 8'h03);
      samp(8'h00, 8'hef, 8'h02);
      host.wr(8'h1d, 8'h00);
      samp(8'h7f, 8'h7f, 8'h01);
      host.wr(8'h1f, 8'h90);
      samp(8'h11, 8'h00, 8'h00);
      host.wr(8'h1d, 8'h02);
      samp(8'h11, 8'h00, 8'h01);
      samp(8'h11, 8'h00, 8'h02);
      samp(8'h10, 8'h00, 8'h00);
      $display("test debounce done");

      outputSampleRate <= 3'h7;
      for (int m = 0; m < 4; m++)
      begin
         oversampleMode <= ttd_mode_type'(m);
         samp(8'h00, 8'h00, 8'h00);
         samp(8'h20, 8'h00, modeInc[m]);
      end
      // saturation from a non-zero level with the widest increment
      oversampleMode <= MODE_HIGH_RESOLUTION;
      samp(8'h20, 8'h00, 8'hff);
      outputSampleRate <= 3'h5;
      oversampleMode <= MODE_NORMAL;
      samp(8'h00, 8'h00, 8'h00);
      samp(8'h20, 8'h00, 8'h04);
      $display("test step size done");

      outputSampleRate <= 3'h0;
      host.wr(8'h20, 8'h00);
      host.wr(8'h1d, 8'h12);
      // register writes leave the counter alone, so clear it first
      samp(8'h00, 8'h00, 8'h00);
      samp(8'hde, 8'h00, 8'h01);
      chk("irq zero count", 8'h01, {7'h0, transientIrq});
      // a second, positive event must not overwrite the frozen flags
      samp(8'h22, 8'h00, 8'h02);
      chk("irq latched", 8'h01, {7'h0, transientIrq});
      rdChk("source frozen", 8'h1e, 8'h43);
      rdChk("source cleared", 8'h1e, 8'h00);
      host.wr(8'h1e, 8'hff);
      rdChk("source read only", 8'h1e, 8'h00);
      $display("test latch done");
      stop_test();
   end
endmodule : tb
